// *** rtl/bks_sequencer.sv ***
`timescale 1ns/100ps
module bks_sequencer
    import bks_pkg::*;
#(
    parameter int unsigned HOLD_CYC = HICCUP_HOLD_CYC,
    parameter int unsigned STEP_INTERVAL = STEP_CYC,
    parameter int unsigned FILT_CYC = PIN_FILT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable_pin,
    input wire logic sel_code_bit0,
    input wire logic sel_code_bit1,
    input wire logic sel_code_bit2,
    input wire logic input_undervoltage_lockout,
    input wire logic overcurrent_protect,
    input wire logic over_temp,
    output logic switching_en,
    output logic hs_gate_en,
    output logic ls_force_on,
    output logic [11:0] voltage_code,
    output logic ext_divider_sel,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    if (HOLD_CYC < 1 || HOLD_CYC > 65535 || STEP_INTERVAL < 1 || STEP_INTERVAL > 255)
    begin : g_chk
        $error("bks_sequencer: HOLD_CYC or STEP_INTERVAL out of range");
    end

    typedef struct packed {
        bks_state_type state;
        logic [11:0] ref_code;
        logic [11:0] target;
        logic ext_mode;
        logic [7:0] step_cnt;
        logic [15:0] hold_cnt;
        logic [15:0] trips;
        logic ctrl_en;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } bks_seq_type;

    bks_seq_type st_q;
    bks_seq_type st_d;

    logic [5:0] slow_lvl;
    logic oc_lvl;
    logic en_s;
    logic input_undervoltage_lockout_s;
    logic ot_s;
    logic [2:0] sel_s;
    logic run_ok;
    logic sel_is_ext;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin qualification

    // lockout enters as supply good, so a cleared filter reads as locked out
    bks_in_filter #(
        .W(6),
        .FILT(FILT_CYC)
    ) u_slow (
        .clk(clk),
        .rst_b(rst_b),
        .pin({over_temp, !input_undervoltage_lockout, enable_pin,
              sel_code_bit2, sel_code_bit1, sel_code_bit0}),
        .level(slow_lvl)
    );

    // Overcurrent only synchronised so a trip is not delayed
    bks_in_filter #(
        .W(1),
        .FILT(1)
    ) u_fast (
        .clk(clk),
        .rst_b(rst_b),
        .pin(overcurrent_protect),
        .level(oc_lvl)
    );

    assign sel_s = slow_lvl[2:0];
    assign en_s = slow_lvl[3];
    assign input_undervoltage_lockout_s = !slow_lvl[4];
    assign ot_s = slow_lvl[5];
    assign sel_is_ext = (sel_s == SEL_EXT_DIV);
    assign run_ok = en_s && st_q.ctrl_en && !input_undervoltage_lockout_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer and register slave

    always_comb begin
        st_d = st_q;

        case (st_q.state)
            BKS_OFF: begin
                st_d.ref_code = REF_ZERO;
                st_d.step_cnt = '0;
                // start condition, soft start from zero
                if (run_ok && !ot_s) begin
                    st_d.state = BKS_RUN;
                    st_d.ext_mode = sel_is_ext;
                    st_d.target = bks_decode(sel_s);
                end
            end
            BKS_RUN: begin
                if (!run_ok) begin
                    st_d.state = BKS_OFF;
                    st_d.ref_code = REF_ZERO;
                end else if (ot_s) begin
                    st_d.state = BKS_THERMAL;
                    st_d.ref_code = REF_ZERO;
                end else if (oc_lvl) begin
                    st_d.state = BKS_HICCUP;
                    st_d.hold_cnt = '0;
                    st_d.ref_code = REF_ZERO;
                    st_d.step_cnt = '0;
                    if (st_q.trips != 16'hFFFF) begin
                        st_d.trips = st_q.trips + 16'h0001;
                    end
                end else begin
                    // new preset only; a mode crossing is held off
                    if (sel_is_ext == st_q.ext_mode) begin
                        st_d.target = bks_decode(sel_s);
                    end
                    // one step per interval, same slew
                    if (st_q.ref_code == st_q.target) begin
                        st_d.step_cnt = '0;
                    end else if (st_q.step_cnt == 8'(STEP_INTERVAL - 1)) begin
                        st_d.step_cnt = '0;
                        if (st_q.ref_code < st_q.target) begin
                            st_d.ref_code = st_q.ref_code + 12'h001;
                        end else begin
                            st_d.ref_code = st_q.ref_code - 12'h001;
                        end
                    end else begin
                        st_d.step_cnt = st_q.step_cnt + 8'h01;
                    end
                end
            end
            BKS_HICCUP: begin
                if (!run_ok) begin
                    st_d.state = BKS_OFF;
                end else if (ot_s) begin
                    st_d.state = BKS_THERMAL;
                end else if (st_q.hold_cnt == 16'(HOLD_CYC - 1)) begin
                    // hold done, restart ramp from zero
                    st_d.state = BKS_RUN;
                    st_d.hold_cnt = '0;
                end else begin
                    st_d.hold_cnt = st_q.hold_cnt + 16'h0001;
                end
            end
            BKS_THERMAL: begin
                st_d.ref_code = REF_ZERO;
                if (!run_ok || !ot_s) begin
                    st_d.state = BKS_OFF;
                end
            end
            default: begin
                st_d.state = BKS_OFF;
                st_d.ref_code = REF_ZERO;
            end
        endcase

        // Write address and data are taken independently
        if (s_axi_awvalid && !st_q.aw_full) begin
            st_d.aw_full = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_full) begin
            st_d.w_full = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
            st_d.aw_full = 1'b0;
            st_d.w_full = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            if (st_q.aw_addr == ADDR_CTRL) begin
                if (st_q.w_strb[0]) begin
                    st_d.ctrl_en = st_q.w_data[0];
                end
            end else if (st_q.aw_addr == ADDR_STATUS || st_q.aw_addr == ADDR_REF ||
                         st_q.aw_addr == ADDR_TRIPS) begin
                st_d.bresp = RESP_OKAY;
            end else begin
                st_d.bresp = RESP_DECERR;
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            st_d.rdata = '0;
            if (s_axi_araddr == ADDR_CTRL) begin
                st_d.rdata[0] = st_q.ctrl_en;
            end else if (s_axi_araddr == ADDR_STATUS) begin
                st_d.rdata[STAT_STATE_LSB +: 4] = st_q.state;
                st_d.rdata[STAT_EXT_BIT] = st_q.ext_mode;
                st_d.rdata[STAT_SETTLED_BIT] = (st_q.state == BKS_RUN) &&
                                               (st_q.ref_code == st_q.target);
                st_d.rdata[STAT_PINS_LSB +: 7] = {oc_lvl, ot_s, input_undervoltage_lockout_s, slow_lvl[3:0]};
            end else if (s_axi_araddr == ADDR_REF) begin
                st_d.rdata[11:0] = st_q.ref_code;
                st_d.rdata[REF_TGT_LSB +: 12] = st_q.target;
            end else if (s_axi_araddr == ADDR_TRIPS) begin
                st_d.rdata[15:0] = st_q.trips;
            end else begin
                st_d.rresp = RESP_DECERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.state <= BKS_OFF;
            st_q.ctrl_en <= CTRL_EN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign switching_en = (st_q.state == BKS_RUN);
    // high side cut as soon as the trip is seen
    assign hs_gate_en = (st_q.state == BKS_RUN) && !oc_lvl;
    assign ls_force_on = (st_q.state == BKS_HICCUP) || ((st_q.state == BKS_RUN) && oc_lvl);
    assign voltage_code = st_q.ref_code;
    assign ext_divider_sel = st_q.ext_mode;

    assign s_axi_awready = !st_q.aw_full;
    assign s_axi_wready = !st_q.w_full;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = st_q.rdata;

endmodule

// *** rtl/bks_pkg.sv ***
package bks_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    // Nominal ramp slew, 1.65 V/ms, in microvolts per millisecond
    localparam int unsigned SLEW_UV_PER_MS = 1_650_000;
    // Reference converter step size in microvolts
    localparam int unsigned DAC_LSB_UV = 1000;
    // Cycles between single-code reference steps
    localparam int unsigned STEP_CYC = (CLK_PER_MS * DAC_LSB_UV) / SLEW_UV_PER_MS;
    // Overcurrent hold time, 1 ms
    localparam int unsigned HICCUP_HOLD_US = 1000;
    localparam int unsigned HICCUP_HOLD_CYC = HICCUP_HOLD_US * (CLK_HZ / 1_000_000);
    // Qualification time for slow pins
    localparam int unsigned PIN_FILT_CYC = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference codes, one code per millivolt
    localparam int unsigned REF_W = 12;
    localparam logic [11:0] REF_ZERO = 12'h000;
    localparam logic [11:0] REF_3V30 = 12'hCE4;
    localparam logic [11:0] REF_2V50 = 12'h9C4;
    localparam logic [11:0] REF_1V80 = 12'h708;
    localparam logic [11:0] REF_1V50 = 12'h5DC;
    localparam logic [11:0] REF_1V25 = 12'h4E2;
    localparam logic [11:0] REF_1V20 = 12'h4B0;
    localparam logic [11:0] REF_0V80 = 12'h320;
    localparam logic [11:0] REF_EXT = 12'h25B;
    localparam logic [2:0] SEL_EXT_DIV = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REF = 8'h08;
    localparam logic [7:0] ADDR_TRIPS = 8'h0C;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_EXT_BIT = 4;
    localparam int unsigned STAT_SETTLED_BIT = 5;
    localparam int unsigned STAT_PINS_LSB = 8;
    localparam int unsigned REF_TGT_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [3:0] {
        BKS_OFF = 4'h1,
        BKS_RUN = 4'h2,
        BKS_HICCUP = 4'h4,
        BKS_THERMAL = 4'h8
    } bks_state_type;

    function automatic logic [11:0] bks_decode(input logic [2:0] sel);
        logic [11:0] code;
        code = REF_EXT;
        case (sel)
            3'h0: code = REF_3V30;
            3'h1: code = REF_2V50;
            3'h2: code = REF_1V80;
            3'h3: code = REF_1V50;
            3'h4: code = REF_1V25;
            3'h5: code = REF_1V20;
            3'h6: code = REF_0V80;
            default: code = REF_EXT;
        endcase
        return code;
    endfunction

endpackage

// *** rtl/bks_in_filter.sv ***
`timescale 1ns/100ps
module bks_in_filter
    import bks_pkg::*;
#(
    parameter int unsigned W = 1,
    parameter int unsigned FILT = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);

    localparam int unsigned CW = $clog2(FILT + 1);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] out;
        logic [W-1:0][CW-1:0] cnt;
    } bks_filt_type;

    bks_filt_type st_q;
    bks_filt_type st_d;

    if (W < 1 || FILT < 1) begin : g_chk
        $error("bks_in_filter: W and FILT must be at least 1");
    end

    // A level must persist FILT cycles before it is taken; this is the
    // time hysteresis that keeps slow indications from chattering
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.out[i]) begin
                st_d.cnt[i] = '0;
            end else if (st_q.cnt[i] == CW'(FILT - 1)) begin
                st_d.out[i] = st_q.s2[i];
                st_d.cnt[i] = '0;
            end else begin
                st_d.cnt[i] = st_q.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.out;

endmodule

// *** tb/bks_checker.sv ***
`timescale 1ns/100ps
module bks_checker
    import bks_pkg::*;
#(
    parameter int unsigned STEP_INTERVAL = STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable_pin,
    input wire logic input_undervoltage_lockout,
    input wire logic overcurrent_protect,
    input wire logic over_temp,
    input wire logic switching_en,
    input wire logic hs_gate_en,
    input wire logic ls_force_on,
    input wire logic [11:0] voltage_code,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [7:0] gap_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // Saturates so a long settled period cannot wrap into a false short gap
    always_ff @(posedge clk) begin
        if (!rst_b)
            gap_q <= 8'h00;
        else if ($changed(voltage_code))
            gap_q <= 8'h00;
        else if (gap_q != 8'hFF)
            gap_q <= gap_q + 8'h01;
    end
    ////////////////////////////////////////
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_gate_excl: assert property (
        hs_gate_en |-> switching_en && !ls_force_on)
        else $error("high side on outside clean run");
    a_oc_trip: assert property (
        switching_en && $past(overcurrent_protect, 3) |-> ls_force_on && !hs_gate_en)
        else $error("overcurrent did not swap the gates");
    a_off_zero: assert property (
        !switching_en |-> voltage_code == REF_ZERO)
        else $error("reference not at start while stopped");
    a_step_one: assert property (
        switching_en && $past(switching_en) && $changed(voltage_code)
        |-> 12'(voltage_code - $past(voltage_code)) inside {12'h001, 12'hFFF})
        else $error("reference moved more than one code");
    a_step_gap: assert property (
        switching_en && $past(switching_en) && $changed(voltage_code)
        |-> gap_q >= STEP_INTERVAL - 1)
        else $error("reference stepped too soon");
    a_input_undervoltage_lockout_off: assert property (
        input_undervoltage_lockout [*8] |-> !switching_en)
        else $error("switching under lockout");
    a_hot_off: assert property (
        over_temp [*8] |-> !switching_en)
        else $error("switching while hot");
    a_en_off: assert property (
        !enable_pin [*8] |-> !switching_en)
        else $error("switching while disabled");
    a_wr_resp: assert property (
        wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_rd_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_rd_hold: assert property (
        rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule

// *** tb/bks_partner.sv ***
`timescale 1ns/100ps
module bks_partner (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en_req,
    input wire logic [2:0] sel_req,
    output logic enable_pin,
    output logic sel_code_bit0,
    output logic sel_code_bit1,
    output logic sel_code_bit2
);
    logic [2:0] sel_q;
    logic mode_flip;
    assign mode_flip = (sel_req == 3'h7) != (sel_q == 3'h7);
    assign {sel_code_bit2, sel_code_bit1, sel_code_bit0} = sel_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable_pin <= 1'h0;
            sel_q <= 3'h3;
        end else begin
            enable_pin <= en_req;
            if (!(enable_pin && mode_flip))
                sel_q <= sel_req;
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench
    import bks_pkg::*;
;
    localparam int unsigned STEP = 2;
    localparam int unsigned HOLD = 200;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic en_req = 1'h1;
    logic [2:0] sel_req = 3'h3;
    logic input_undervoltage_lockout = 1'h1;
    logic overcurrent_protect = 1'h0;
    logic over_temp = 1'h0;
    logic enable_pin, sel_code_bit0, sel_code_bit1, sel_code_bit2;
    logic switching_en, hs_gate_en, ls_force_on, ext_divider_sel;
    logic [11:0] voltage_code;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    int err_count = 0, cmp_count = 0, cyc = 0, n = 0;
    logic [11:0] tab [8] = '{REF_3V30, REF_2V50, REF_1V80, REF_1V50,
        REF_1V25, REF_1V20, REF_0V80, REF_EXT};

    bks_sequencer #(.HOLD_CYC(HOLD), .STEP_INTERVAL(STEP), .FILT_CYC(2)) u_bks_sequencer (
        .clk, .rst_b, .enable_pin, .sel_code_bit0, .sel_code_bit1, .sel_code_bit2,
        .input_undervoltage_lockout, .overcurrent_protect, .over_temp, .switching_en,
        .hs_gate_en, .ls_force_on, .voltage_code, .ext_divider_sel, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    bks_partner u_bks_partner (.clk, .rst_b, .en_req, .sel_req, .enable_pin,
        .sel_code_bit0, .sel_code_bit1, .sel_code_bit2);

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            test_done();
        end
    end
    ////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Ready is sampled mid-cycle, where it equals its value at the next edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tk;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (ta)
                s_axi_awvalid <= 1'h0;
            if (tw)
                s_axi_wvalid <= 1'h0;
        end while (!tk);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tk;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tk = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ta)
                s_axi_arvalid <= 1'h0;
        end while (!tk);
        s_axi_rready <= 1'h0;
    endtask
    task automatic wait_code(input logic [11:0] e, output int k);
        k = 0;
        while (voltage_code !== e && k < 20000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 20000) begin
            err_count++;
            $display("unexpected wait_code exp %0h got %0h", e, voltage_code);
        end
    endtask
    task automatic wait_sw(input logic v, output int k);
        k = 0;
        while (switching_en !== v && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000) begin
            err_count++;
            $display("unexpected wait_sw exp %0h got %0h", v, switching_en);
        end
    endtask
    task automatic set(input logic u, input logic o, input logic h);
        @(posedge clk);
        input_undervoltage_lockout <= u;
        overcurrent_protect <= o;
        over_temp <= h;
    endtask
    task automatic req(input logic e, input logic [2:0] s);
        @(posedge clk);
        en_req <= e;
        sel_req <= s;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        repeat (40) @(negedge clk);
        `CHK("sw_lock", 1'h0, switching_en)
        rd_reg(ADDR_CTRL, rd, rsp);
        `CHK("ctrl", 1'h1, rd[0])
        rd_reg(ADDR_STATUS, rd, rsp);
        `CHK("state_off", BKS_OFF, rd[3:0])
        rd_reg(8'h10, rd, rsp);
        `CHK("decerr", RESP_DECERR, rsp)
        set(1'h0, 1'h0, 1'h0);
        wait_sw(1'h1, n);
        wait_code(REF_1V50, n);
        `CHK("ramp_time", 1'h1, n >= 1500 * STEP - 4 && n <= 1500 * STEP + 4)
        rd_reg(ADDR_REF, rd, rsp);
        `CHK("target", REF_1V50, rd[27:16])
        $display("test startup done");
        for (int i = 0; i < 7; i++) begin
            req(1'h1, 3'(i));
            wait_code(tab[i], n);
            `CHK("preset", tab[i], voltage_code)
            `CHK("still_run", 1'h1, switching_en)
            `CHK("ext_off", 1'h0, ext_divider_sel)
        end
        $display("test presets done");
        set(1'h0, 1'h1, 1'h0);
        wait_sw(1'h0, n);
        `CHK("ls_on", 1'h1, ls_force_on)
        `CHK("hs_off", 1'h0, hs_gate_en)
        wait_sw(1'h1, n);
        `CHK("hold", 1'h1, n >= HOLD - 2 && n <= HOLD + 4)
        wait_sw(1'h0, n);
        `CHK("retrip", 1'h1, n < 10)
        rd_reg(ADDR_TRIPS, rd, rsp);
        `CHK("trips", 1'h1, rd[15:0] >= 16'h0002)
        set(1'h1, 1'h0, 1'h0);
        repeat (20) @(negedge clk);
        rd_reg(ADDR_STATUS, rd, rsp);
        `CHK("lock_wins", BKS_OFF, rd[3:0])
        set(1'h0, 1'h0, 1'h0);
        wait_sw(1'h1, n);
        `CHK("from_zero", 1'h1, voltage_code < 12'h010)
        wait_code(REF_0V80, n);
        $display("test faults done");
        set(1'h0, 1'h0, 1'h1);
        wait_sw(1'h0, n);
        rd_reg(ADDR_STATUS, rd, rsp);
        `CHK("hot", BKS_THERMAL, rd[3:0])
        set(1'h0, 1'h0, 1'h0);
        wait_sw(1'h1, n);
        wait_code(REF_0V80, n);
        `CHK("cool_ramp", 1'h1, n >= 800 * STEP - 4)
        $display("test thermal done");
        req(1'h0, 3'h7);
        wait_sw(1'h0, n);
        `CHK("en_off", 1'h1, n < 20)
        repeat (20) @(negedge clk);
        req(1'h1, 3'h7);
        wait_code(REF_EXT, n);
        `CHK("ext_on", 1'h1, ext_divider_sel)
        req(1'h1, 3'h3);
        repeat (30) @(negedge clk);
        `CHK("mode_kept", REF_EXT, voltage_code)
        wr(ADDR_CTRL, 32'h0, rsp);
        `CHK("wr_ok", RESP_OKAY, rsp)
        wait_sw(1'h0, n);
        `CHK("soft_off", 1'h1, n < 20)
        wr(ADDR_STATUS, 32'hF, rsp);
        `CHK("ro_ok", RESP_OKAY, rsp)
        wr(ADDR_CTRL, 32'h1, rsp);
        wait_sw(1'h1, n);
        wait_code(REF_EXT, n);
        `CHK("rerun", 1'h1, ext_divider_sel)
        $display("test enable done");
        test_done();
    end
endmodule
bind bks_sequencer bks_checker #(.STEP_INTERVAL(STEP_INTERVAL)) u_bks_checker (
    .clk, .rst_b, .enable_pin, .input_undervoltage_lockout, .overcurrent_protect,
    .over_temp, .switching_en, .hs_gate_en, .ls_force_on, .voltage_code, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
